/* File: synth_ctrl_regs.vh */
// Constants for the synthesizer serial control block
`ifndef SYNTH_CTRL_REGS_VH
`define SYNTH_CTRL_REGS_VH

// Register offsets (word index on the local register port)
`define REG_STATUS      4'h0
`define REG_MASK        4'h1
`define REG_REF_LATCH   4'h2
`define REG_FB_LATCH    4'h3
`define REG_STATE       4'h4

// Status and mask bit positions
`define EV_LOCK_GAINED  0
`define EV_LOCK_LOST    1
`define EV_LATCH_LOAD   2
`define EV_POWER_DOWN   3
`define EV_W            4

// Shift word layout: control bit in bit 0
`define SHIFT_W         21
`define CTRL_BIT        0
`define REF_CNT_LSB     1
`define REF_CNT_W       14
`define PRE_SEL_BIT     15
`define FB_CNT_LSB      1
`define FB_CNT_W        20

// Reset values of the latches
`define REF_LATCH_RST   14'h000A
`define FB_LATCH_RST    20'h00040

// Lock window: pump pulses narrower than this count as locked
`define LOCK_WIN_NS     50
`define CLK_PERIOD_NS   10
`define LOCK_WIN_CYC    (`LOCK_WIN_NS / `CLK_PERIOD_NS)

`endif

/* File: pin_sync.v */
// Two-flop synchroniser for a group of pins
`default_nettype none

module pin_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         reset,
    // Pins in, synchronised levels out
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage is read only by the second stage
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;

endmodule // pin_sync

`default_nettype wire

/* File: synth_ctrl.v */
// Serial programming, phase detector and power-down control of a synthesizer
// What this block does
// - Sample serial data on each rising serial clock edge into the shift register.
// - Words arrive MSB first; the final LSB selects the destination latch.
// - Rising load strobe copies the shift register into the selected latch.
// - Low polarity select inverts the pump sense only, not the phase pulse outputs; high is normal.
// - While load strobe is high the loop switch mirrors the charge pump output.
// - Lock indicator stays high when locked, with only narrow low pulses.
// - Power-down input high means normal operation; low requests power saving.
// - Power-down entry waits until the charge pump is back at high impedance.
// - Prescaler offers a selectable pair of dual-modulus ratios.
// - A logic output mirrors a phase comparator input for monitoring.
// - Phase pulses leave on one push-pull output and one open-drain output.
`include "synth_ctrl_regs.vh"
`default_nettype none

module synth_ctrl #(
    parameter SHIFT_W = `SHIFT_W,
    parameter REF_W   = `REF_CNT_W,
    parameter FB_W    = `FB_CNT_W
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Three-wire serial port pins
    input  wire        ser_clk,
    input  wire        ser_data,
    input  wire        load_strobe,
    // Control pins
    input  wire        phase_polarity_select,
    input  wire        power_down_n,
    // Loop inputs, sampled as logic levels
    input  wire        ref_osc_in,
    input  wire        prescaler_in,
    // Loop outputs
    output reg         ref_osc_out,
    output reg         pump_up,
    output reg         pump_dn,
    output reg         loop_switch_on,
    output reg         loop_switch_up,
    output reg         loop_switch_dn,
    output reg         lock_indicator,
    output reg         monitor_out,
    output reg         phase_ref_out,
    output wire        phase_fb_o,
    output reg         phase_fb_oe,
    output reg         prescaler_ratio_sel,
    output reg         powered_down,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Interrupt
    output wire        irq
);

    // Phase detector states, one-hot
    localparam [2:0] PD_IDLE = 3'b001;
    localparam [2:0] PD_REF  = 3'b010;
    localparam [2:0] PD_FB   = 3'b100;

    // Synchronised pins
    wire [6:0] pins_s;
    wire       sclk_s;
    wire       sdat_s;
    wire       le_s;
    wire       pol_s;
    wire       power_down_n_n_s;
    wire       ref_s;
    wire       pre_s;

    pin_sync #(
        .W       (7)
    ) u_pin_sync (
        .mclk    (mclk),
        .reset   (reset),
        .pin_in  ({ser_clk, ser_data, load_strobe, phase_polarity_select,
                   ~power_down_n, ref_osc_in, prescaler_in}),
        .pin_out (pins_s)
    );

    assign sclk_s   = pins_s[6];
    assign sdat_s   = pins_s[5];
    assign le_s     = pins_s[4];
    assign pol_s    = pins_s[3];
    // Carried inverted so the cleared sync flops read as the idle high level,
    // otherwise every reset would fake a short power-down request
    assign power_down_n_n_s = ~pins_s[2];
    assign ref_s    = pins_s[1];
    assign pre_s    = pins_s[0];

    // Edge detection history
    reg sclk_d_q;
    reg le_d_q;
    reg ref_d_q;
    reg pre_d_q;
    wire sclk_rise = sclk_s & ~sclk_d_q;
    wire le_rise   = le_s & ~le_d_q;
    wire ref_rise  = ref_s & ~ref_d_q;
    wire pre_rise  = pre_s & ~pre_d_q;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclk_d_q <= 1'b0;
            le_d_q   <= 1'b0;
            ref_d_q  <= 1'b0;
            pre_d_q  <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
            le_d_q   <= le_s;
            ref_d_q  <= ref_s;
            pre_d_q  <= pre_s;
        end
    end

    // Serial shift register and latches
    reg [SHIFT_W-1:0] shift_q;
    reg [REF_W-1:0]   ref_latch_q;
    reg [FB_W-1:0]    fb_latch_q;
    reg               pre_sel_q;
    reg               latch_ev;

    // Shift on serial clock; host keeps it low around strobe edges, so the
    // two never coincide and the word is stable when the strobe rises
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            shift_q     <= {SHIFT_W{1'b0}};
            ref_latch_q <= `REF_LATCH_RST;
            fb_latch_q  <= `FB_LATCH_RST;
            pre_sel_q   <= 1'b0;
            latch_ev    <= 1'b0;
        end else begin
            latch_ev <= 1'b0;
            if (sclk_rise) begin
                shift_q <= {shift_q[SHIFT_W-2:0], sdat_s};
            end
            if (le_rise) begin
                latch_ev <= 1'b1;
                if (shift_q[`CTRL_BIT]) begin
                    ref_latch_q <= shift_q[`REF_CNT_LSB +: REF_W];
                    pre_sel_q   <= shift_q[`PRE_SEL_BIT];
                end else begin
                    fb_latch_q  <= shift_q[`FB_CNT_LSB +: FB_W];
                end
            end
        end
    end

    // Prescaler ratio pair select drives the external modulus choice
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            prescaler_ratio_sel <= 1'b0;
        end else begin
            prescaler_ratio_sel <= pre_sel_q;
        end
    end

    // Power-down handling
    reg  [2:0] pd_state_q;
    wire       pump_idle = (pd_state_q == PD_IDLE);

    // Entry waits for the pump pins to go quiet so no charge is dumped mid-pulse;
    // the pump outputs lag the detector state by one cycle, so both are checked
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            powered_down <= 1'b0;
        end else if (power_down_n_n_s) begin
            powered_down <= 1'b0;
        end else if (pump_idle && !pump_up && !pump_dn) begin
            powered_down <= 1'b1;
        end
    end

    // Reference and feedback dividers; cleared while powered down
    reg  [REF_W-1:0] ref_cnt_q;
    reg  [FB_W-1:0]  fb_cnt_q;
    reg              ref_tick;
    reg              fb_tick;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ref_cnt_q <= {REF_W{1'b0}};
            fb_cnt_q  <= {FB_W{1'b0}};
            ref_tick  <= 1'b0;
            fb_tick   <= 1'b0;
        end else if (powered_down) begin
            ref_cnt_q <= {REF_W{1'b0}};
            fb_cnt_q  <= {FB_W{1'b0}};
            ref_tick  <= 1'b0;
            fb_tick   <= 1'b0;
        end else begin
            ref_tick <= 1'b0;
            fb_tick  <= 1'b0;
            if (ref_rise) begin
                if (ref_cnt_q + 1'b1 >= ref_latch_q) begin
                    ref_cnt_q <= {REF_W{1'b0}};
                    ref_tick  <= 1'b1;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 1'b1;
                end
            end
            if (pre_rise) begin
                if (fb_cnt_q + 1'b1 >= fb_latch_q) begin
                    fb_cnt_q <= {FB_W{1'b0}};
                    fb_tick  <= 1'b1;
                end else begin
                    fb_cnt_q <= fb_cnt_q + 1'b1;
                end
            end
        end
    end

    // Monitor output follows the divided reference seen by the comparator
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            monitor_out <= 1'b0;
            ref_osc_out <= 1'b1;
        end else begin
            monitor_out <= ref_tick;
            ref_osc_out <= ~ref_s;
        end
    end

    // Phase-frequency detector: leading edge opens a pulse, lagging one ends it
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pd_state_q <= PD_IDLE;
        end else if (powered_down) begin
            pd_state_q <= PD_IDLE;
        end else begin
            case (pd_state_q)
                PD_IDLE: begin
                    if (ref_tick && !fb_tick) begin
                        pd_state_q <= PD_REF;
                    end else if (fb_tick && !ref_tick) begin
                        pd_state_q <= PD_FB;
                    end
                end
                PD_REF: begin
                    if (fb_tick) begin
                        pd_state_q <= PD_IDLE;
                    end
                end
                PD_FB: begin
                    if (ref_tick) begin
                        pd_state_q <= PD_IDLE;
                    end
                end
                default: begin
                    pd_state_q <= PD_IDLE;
                end
            endcase
        end
    end

    // Pump drive with polarity select applied
    wire up_raw = (pd_state_q == PD_REF);
    wire dn_raw = (pd_state_q == PD_FB);
    wire up_sel = pol_s ? up_raw : dn_raw;
    wire dn_sel = pol_s ? dn_raw : up_raw;

    // Pump, loop switch and comparator pulse outputs
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pump_up        <= 1'b0;
            pump_dn        <= 1'b0;
            loop_switch_on <= 1'b0;
            loop_switch_up <= 1'b0;
            loop_switch_dn <= 1'b0;
            phase_ref_out  <= 1'b0;
            phase_fb_oe    <= 1'b0;
        end else begin
            pump_up        <= up_sel;
            pump_dn        <= dn_sel;
            loop_switch_on <= le_s;
            loop_switch_up <= le_s & up_sel;
            loop_switch_dn <= le_s & dn_sel;
            phase_ref_out  <= up_raw;
            phase_fb_oe    <= dn_raw;
        end
    end

    // Open-drain output only ever pulls low
    assign phase_fb_o = 1'b0;

    // Lock detection: measure each pump pulse against the lock window
    reg [7:0] pulse_len_q;
    reg       locked_q;
    reg       lock_gain_ev;
    reg       lock_lost_ev;
    wire      pump_busy = ~pump_idle;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pulse_len_q  <= 8'h00;
            locked_q     <= 1'b0;
            lock_gain_ev <= 1'b0;
            lock_lost_ev <= 1'b0;
        end else begin
            lock_gain_ev <= 1'b0;
            lock_lost_ev <= 1'b0;
            if (pump_busy) begin
                if (pulse_len_q != 8'hFF) begin
                    pulse_len_q <= pulse_len_q + 8'h01;
                end
                if (pulse_len_q >= `LOCK_WIN_CYC && locked_q) begin
                    locked_q     <= 1'b0;
                    lock_lost_ev <= 1'b1;
                end
            end else begin
                pulse_len_q <= 8'h00;
                if (pulse_len_q != 8'h00 && pulse_len_q < `LOCK_WIN_CYC && !locked_q) begin
                    locked_q     <= 1'b1;
                    lock_gain_ev <= 1'b1;
                end
            end
        end
    end

    // High while locked, dropping only for the narrow pump pulses
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            lock_indicator <= 1'b0;
        end else begin
            lock_indicator <= locked_q & pump_idle;
        end
    end

    // Power-down entry event
    reg pd_d_q;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pd_d_q <= 1'b0;
        end else begin
            pd_d_q <= powered_down;
        end
    end

    // Sticky status, mask and interrupt
    reg  [`EV_W-1:0] status_q;
    reg  [`EV_W-1:0] mask_q;
    wire [`EV_W-1:0] events;
    wire             status_rd = reg_rd && (reg_addr == `REG_STATUS);

    assign events = {powered_down & ~pd_d_q, latch_ev, lock_lost_ev, lock_gain_ev};

    // A set arriving with the clearing read still wins
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            status_q <= {`EV_W{1'b0}};
        end else begin
            status_q <= (status_rd ? {`EV_W{1'b0}} : status_q) | events;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            mask_q <= {`EV_W{1'b0}};
        end else if (reg_wr && reg_addr == `REG_MASK) begin
            mask_q <= reg_wdata[`EV_W-1:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // Register read data, one cycle after the strobe, zero otherwise
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_STATUS:    reg_rdata <= {{(32-`EV_W){1'b0}}, status_q};
                `REG_MASK:      reg_rdata <= {{(32-`EV_W){1'b0}}, mask_q};
                `REG_REF_LATCH: reg_rdata <= {{(31-REF_W){1'b0}}, pre_sel_q, ref_latch_q};
                `REG_FB_LATCH:  reg_rdata <= {{(32-FB_W){1'b0}}, fb_latch_q};
                `REG_STATE:     reg_rdata <= {27'h0000000, powered_down, locked_q, pd_state_q};
                default:        reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // synth_ctrl

`default_nettype wire

/* File: synth_ctrl_asserts.sv */
// Port-level concurrent checks for the synthesizer control block
`default_nettype none

module synth_ctrl_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // Pins and outputs watched
    input wire logic        load_strobe,
    input wire logic        power_down_n,
    input wire logic        pump_up,
    input wire logic        pump_dn,
    input wire logic        loop_switch_on,
    input wire logic        loop_switch_up,
    input wire logic        loop_switch_dn,
    input wire logic        lock_indicator,
    input wire logic        phase_ref_out,
    input wire logic        phase_fb_o,
    input wire logic        phase_fb_oe,
    input wire logic        prescaler_ratio_sel,
    input wire logic        powered_down,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);

    // Strobe pin passes two sync flops and one register before the switch moves
    a_switch_closes: assert property ($rose(load_strobe) |-> ##[2:5] loop_switch_on)
        else $error("loop switch did not close after strobe rise");
    a_switch_opens: assert property ($fell(load_strobe) |-> ##[2:5] !loop_switch_on)
        else $error("loop switch did not open after strobe fall");
    a_switch_copies: assert property (loop_switch_up == (loop_switch_on && pump_up) &&
                                      loop_switch_dn == (loop_switch_on && pump_dn))
        else $error("switch output does not follow the pump");
    // Power-down may only start with the pump already idle
    a_pd_gated: assert property ($rose(powered_down) |-> !$past(pump_up) && !$past(pump_dn))
        else $error("power-down entered while pump active");
    a_pd_enters: assert property ((!power_down_n && !pump_up && !pump_dn)[*6] |-> powered_down)
        else $error("power-down not entered");
    // Eight cycles cover the two sync flops and the output register
    a_pd_leaves: assert property (power_down_n[*8] |-> !powered_down)
        else $error("still powered down with the pin high");
    a_lock_dips: assert property ((pump_up || pump_dn) |-> ##[0:1] !lock_indicator)
        else $error("lock indicator high during pump pulse");
    a_fb_low_only: assert property (phase_fb_o == 1'b0 && !(phase_ref_out && phase_fb_oe))
        else $error("open-drain output driven high or both phase outputs active");
    a_latch_hold: assert property (!load_strobe[*8] |-> $stable(prescaler_ratio_sel))
        else $error("latch changed without a strobe");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read cycle");

    // Main scenarios reached
    cover property ($rose(loop_switch_on));
    cover property ($rose(powered_down));
    cover property (pump_dn && loop_switch_on);
endmodule // synth_ctrl_asserts

bind synth_ctrl synth_ctrl_asserts chk_u (
    .mclk(mclk), .reset(reset), .load_strobe(load_strobe), .power_down_n(power_down_n),
    .pump_up(pump_up), .pump_dn(pump_dn), .loop_switch_on(loop_switch_on),
    .loop_switch_up(loop_switch_up), .loop_switch_dn(loop_switch_dn), .lock_indicator(lock_indicator),
    .phase_ref_out(phase_ref_out), .phase_fb_o(phase_fb_o), .phase_fb_oe(phase_fb_oe),
    .prescaler_ratio_sel(prescaler_ratio_sel), .powered_down(powered_down),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

`default_nettype wire

/* File: synth_host_model.sv */
// Behavioural host programming the synthesizer over its three-wire port
`default_nettype none

module synth_host_model (
    // Three-wire port
    output var logic ser_clk,
    output var logic ser_data,
    output var logic load_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Port idles low; the serial clock stands still between frames
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end

    // Twenty-three bits MSB first, so the top two fall off the 21-bit register
    task automatic send_word(input logic [22:0] w);
        // Move off the system clock edge so no pin changes race its sampling
        #3;
        for (int i = 22; i >= 0; i--) begin
            ser_data = w[i];
            #40 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
            #40;
        end
        // Released data line shows the inverse, never a stale level
        ser_data = ~w[0];
        // Clock is low across both strobe edges; long strobe lets pump pulses reach the switch
        #40 load_strobe = 1'b1;
        #400 load_strobe = 1'b0;
        #80;
    endtask
endmodule // synth_host_model

`default_nettype wire

/* File: synth_ctrl_tb_top.sv */
// Self-checking testbench for the synthesizer control block
`include "synth_ctrl_regs.vh"
`default_nettype none

module synth_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        phase_polarity_select = 1'b1;
    logic        power_down_n = 1'b1;
    logic        ref_osc_in = 1'b0;
    logic        prescaler_in = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        loop_run = 1'b0;
    logic        count_en = 1'b0;
    logic [2:0]  phase_q = 3'h0;
    logic [31:0] rd;
    wire logic   ser_clk, ser_data, load_strobe;
    wire logic   ref_osc_out, pump_up, pump_dn, loop_switch_on, loop_switch_up, loop_switch_dn;
    wire logic   lock_indicator, monitor_out, phase_ref_out, phase_fb_o, phase_fb_oe;
    wire logic   prescaler_ratio_sel, powered_down, irq;
    wire logic [31:0] reg_rdata;
    int num_errors = 0;
    int num_checks = 0;
    int cycle_cnt = 0;
    int n_up, n_dn, n_sw, n_mon, n_ref, n_oe, n_osc;

    synth_host_model host_u (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));

    synth_ctrl dut_u (
        .mclk(mclk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
        .phase_polarity_select(phase_polarity_select), .power_down_n(power_down_n),
        .ref_osc_in(ref_osc_in), .prescaler_in(prescaler_in), .ref_osc_out(ref_osc_out),
        .pump_up(pump_up), .pump_dn(pump_dn), .loop_switch_on(loop_switch_on),
        .loop_switch_up(loop_switch_up), .loop_switch_dn(loop_switch_dn), .lock_indicator(lock_indicator),
        .monitor_out(monitor_out), .phase_ref_out(phase_ref_out), .phase_fb_o(phase_fb_o),
        .phase_fb_oe(phase_fb_oe), .prescaler_ratio_sel(prescaler_ratio_sel), .powered_down(powered_down),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq)
    );

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // Reference leads feedback by three cycles; equal dividers keep the loop locked
    always @(posedge mclk) begin
        if (loop_run) begin
            phase_q <= phase_q + 3'h1;
            ref_osc_in <= (phase_q < 3'h4);
            prescaler_in <= (phase_q - 3'h3 < 3'h4);
        end
    end

    // Tally loop activity while a window is open
    always @(posedge mclk) begin
        if (count_en) begin
            n_up += pump_up;
            n_dn += pump_dn;
            n_sw += loop_switch_up | loop_switch_dn;
            n_mon += monitor_out;
            n_ref += phase_ref_out;
            n_oe += phase_fb_oe;
            n_osc += !ref_osc_out;
        end
    end

    // Cut a hang short
    always @(posedge mclk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic expect_reg(input string name, input logic [3:0] a, input logic [31:0] exp);
        reg_read(a);
        check(name, exp, rd);
    endtask

    // Step the loop to a point where both inputs are low and every pulse is closed
    task automatic loop_quiet();
        do begin
            @(posedge mclk);
            #1;
        end while (phase_q !== 3'h0 || pump_up !== 1'b0 || pump_dn !== 1'b0);
    endtask

    task automatic t_reset_values();
        expect_reg("ref latch", `REG_REF_LATCH, {18'h0, `REF_LATCH_RST});
        expect_reg("fb latch", `REG_FB_LATCH, {12'h0, `FB_LATCH_RST});
        reg_write(`REG_REF_LATCH, 32'hFFFFFFFF);
        expect_reg("latch after write", `REG_REF_LATCH, {18'h0, `REF_LATCH_RST});
        expect_reg("unmapped", 4'hF, 32'h0);
        check("ratio sel", 32'h0, prescaler_ratio_sel);
        $display("test reset values done");
    endtask

    task automatic t_load_ref();
        reg_write(`REG_MASK, 32'h00000004);
        host_u.send_word({2'b11, 5'h00, 1'b1, 14'h0004, 1'b1});
        check("irq on load", 32'h1, irq);
        expect_reg("ref latch", `REG_REF_LATCH, 32'h00004004);
        expect_reg("fb untouched", `REG_FB_LATCH, {12'h0, `FB_LATCH_RST});
        check("ratio sel", 32'h1, prescaler_ratio_sel);
        reg_read(`REG_STATUS);
        check("load event", 32'h4, rd & 32'h4);
        check("irq cleared", 32'h0, irq);
        $display("test ref load done");
    endtask

    task automatic t_load_fb();
        reg_write(`REG_MASK, 32'h0);
        host_u.send_word({2'b10, 20'h00004, 1'b0});
        check("irq masked", 32'h0, irq);
        expect_reg("fb latch", `REG_FB_LATCH, 32'h00000004);
        expect_reg("ref untouched", `REG_REF_LATCH, 32'h00004004);
        reg_read(`REG_STATUS);
        check("load event", 32'h4, rd & 32'h4);
        $display("test fb load done");
    endtask

    task automatic t_polarity();
        loop_run <= 1'b1;
        repeat (100) @(posedge mclk);
        {n_up, n_dn, n_sw, n_mon, n_ref, n_oe, n_osc} = '0;
        count_en <= 1'b1;
        repeat (128) @(posedge mclk);
        count_en <= 1'b0;
        check("up pulses", 32'h1, n_up > 0);
        check("down pulses", 32'h0, n_dn);
        check("monitor pulses", 32'h1, n_mon > 0);
        check("ref pulses", 32'h1, n_ref > 0);
        check("fb pulls", 32'h0, n_oe);
        // Inverted reference is low four cycles in every eight of the window
        check("osc out low", 32'h40, n_osc);
        loop_quiet();
        check("locked", 32'h1, lock_indicator);
        phase_polarity_select <= 1'b0;
        repeat (64) @(posedge mclk);
        {n_up, n_dn, n_sw, n_mon, n_ref, n_oe} = '0;
        count_en <= 1'b1;
        host_u.send_word({2'b10, 20'h00004, 1'b0});
        count_en <= 1'b0;
        check("inv up pulses", 32'h0, n_up);
        check("inv down pulses", 32'h1, n_dn > 0);
        check("switch pulses", 32'h1, n_sw > 0);
        $display("test polarity done");
    endtask

    task automatic t_power_down();
        while (pump_dn !== 1'b1) @(posedge mclk);
        power_down_n <= 1'b0;
        loop_quiet();
        loop_run <= 1'b0;
        for (int i = 0; i < 20 && powered_down !== 1'b1; i++) @(posedge mclk);
        check("powered down", 32'h1, powered_down);
        power_down_n <= 1'b1;
        for (int i = 0; i < 20 && powered_down !== 1'b0; i++) @(posedge mclk);
        check("powered up", 32'h0, powered_down);
        $display("test power down done");
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset_values();
        t_load_ref();
        t_load_fb();
        t_polarity();
        t_power_down();
        give_verdict();
    end
endmodule // synth_ctrl_tb_top

`default_nettype wire
